// File: include/msv_map.vh
// How it works
// - writes retained and drive machine parameters
// - every variable is 32-bit signed
// - workpiece count increments on program end
// - machining time read-only, milliseconds
// - actual spindle speed read-only rpm
// - speed command loads programmed speed
// - tool command loads target tool, offset
// - tool change done loads current tool
// - G/M key in auto stores 71/77
// - other write, X key, auto entry clear
// - timers decrement per ms in auto
// - encoder position read-only, 0 to 4xlines
// - branch key reads 71, 77 or 0
`ifndef MSV_MAP_VH
`define MSV_MAP_VH
`define MSV_OFS_WORKPIECE_COUNT 12'h000
`define MSV_OFS_MACHINING_TIME 12'h004
`define MSV_OFS_SPEED_ACTUAL 12'h008
`define MSV_OFS_SPEED_PROGRAMMED 12'h00c
`define MSV_OFS_TARGET_TOOL_NUMBER 12'h010
`define MSV_OFS_TARGET_TOOL_OFFSET 12'h014
`define MSV_OFS_CURRENT_TOOL_NUMBER 12'h018
`define MSV_OFS_CURRENT_TOOL_OFFSET 12'h01c
`define MSV_OFS_BRANCH_KEY 12'h020
`define MSV_OFS_TIMER_A 12'h024
`define MSV_OFS_TIMER_B 12'h028
`define MSV_OFS_ENCODER_POSITION 12'h02c
`define MSV_OFS_TIME_CONTROL 12'h030
`define MSV_KEY_G 32'h00000047
`define MSV_KEY_M 32'h0000004d
`define MSV_OFFSET_MAX 32'h00000040
`define MSV_TIMER_MAX 32'h05f5e0ff
`define MSV_TICK_MS 16'h0001
`define MSV_CLK_KHZ 16'h9c40
`define MSV_TICK_CYCLES (`MSV_TICK_MS * `MSV_CLK_KHZ)
`define MSV_CTL_RUN_BIT 0
`define MSV_CTL_CLEAR_BIT 1
`endif

// File: rtl/msv_bank.v
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "msv_map.vh"
module msv_bank (
    // apb slave
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    // machine mode and operator keys (one-cycle pulses)
    input wire auto_mode,
    input wire key_g,
    input wire key_m,
    input wire key_x,
    // program interpreter events (one-cycle pulses)
    input wire program_end,
    input wire speed_cmd,
    input wire [31:0] speed_cmd_value,
    input wire tool_cmd,
    input wire [31:0] tool_cmd_number,
    input wire [31:0] tool_cmd_offset,
    input wire tool_change_done,
    input wire [31:0] tool_done_number,
    input wire [31:0] tool_done_offset,
    // measured spindle values
    input wire [31:0] spindle_rpm,
    input wire [31:0] encoder_count,
    input wire [31:0] encoder_line_count_setting,
    // machine parameter outputs driven by writes
    output reg [31:0] workpiece_count,
    output reg [31:0] target_tool_number,
    output reg [31:0] target_tool_offset,
    output reg [31:0] operator_branch_key,
    output reg param_write
);

////////////////////////////////////////////////////////////////////////
// apb decode; zero wait states, unmapped offsets answer with pslverr

// access phase strobe; a write lands on the edge that ends the access
wire wr_en = psel && penable && pwrite;
// reads are captured in the setup cycle so prdata is settled for the access edge
wire rd_setup = psel && !penable && !pwrite;
reg mapped;
// every word is a flop or a live input, so no wait state is ever needed
assign pready = 1'b1;
// only unmapped offsets err; writes to read-only words are dropped quietly
assign pslverr = psel && penable && !mapped;

// address decode
// the time control word lives only here; it drives no machine parameter
always @*
begin
    case (paddr)
        `MSV_OFS_WORKPIECE_COUNT, `MSV_OFS_MACHINING_TIME,
        `MSV_OFS_SPEED_ACTUAL, `MSV_OFS_SPEED_PROGRAMMED,
        `MSV_OFS_TARGET_TOOL_NUMBER, `MSV_OFS_TARGET_TOOL_OFFSET,
        `MSV_OFS_CURRENT_TOOL_NUMBER, `MSV_OFS_CURRENT_TOOL_OFFSET,
        `MSV_OFS_BRANCH_KEY, `MSV_OFS_TIMER_A, `MSV_OFS_TIMER_B,
        `MSV_OFS_ENCODER_POSITION, `MSV_OFS_TIME_CONTROL:
            mapped = 1'b1;
        default:
            mapped = 1'b0;
    endcase
end

// per-register write strobes
wire wr_count = wr_en && paddr == `MSV_OFS_WORKPIECE_COUNT;
wire wr_ttool = wr_en && paddr == `MSV_OFS_TARGET_TOOL_NUMBER;
wire wr_toff = wr_en && paddr == `MSV_OFS_TARGET_TOOL_OFFSET;
wire wr_key = wr_en && paddr == `MSV_OFS_BRANCH_KEY;
wire wr_ta = wr_en && paddr == `MSV_OFS_TIMER_A;
wire wr_tb = wr_en && paddr == `MSV_OFS_TIMER_B;
// wr_ctl has no machine parameter behind it, so it raises no param_write
wire wr_ctl = wr_en && paddr == `MSV_OFS_TIME_CONTROL;

////////////////////////////////////////////////////////////////////////
// shared tick and timers

wire tick_ms;
wire [31:0] timer_a;
wire [31:0] timer_b;
reg auto_q;
// auto_q resets low, so auto held through reset counts as an entry
wire auto_entry = auto_mode && !auto_q;

// one shared tick keeps timers and machining time in step
msv_ms_tick u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick_ms(tick_ms)
);

// values above the limit saturate, negatives load zero
// software gets no error for an out-of-range load; it reads the clamped value
function [31:0] clamp_timer;
    input [31:0] v;
    begin
        if (v[31])
            clamp_timer = 32'h00000000;
        else if (v > `MSV_TIMER_MAX)
            clamp_timer = `MSV_TIMER_MAX;
        else
            clamp_timer = v;
    end
endfunction

// offset number held inside 0..64
function [31:0] clamp_offset;
    input [31:0] v;
    begin
        if (v[31])
            clamp_offset = 32'h00000000;
        else if (v > `MSV_OFFSET_MAX)
            clamp_offset = `MSV_OFFSET_MAX;
        else
            clamp_offset = v;
    end
endfunction

// two independent timers
// one instance per timer; they share only the tick, auto_mode and the write data
genvar gi;
generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_timer
        wire [31:0] tv;
        msv_countdown u_cd (
            .pclk(pclk),
            .presetn(presetn),
            .tick_ms(tick_ms),
            .auto_mode(auto_mode),
            .load(gi == 0 ? wr_ta : wr_tb),
            .load_value(clamp_timer(pwdata)),
            .value(tv)
        );
    end
endgenerate
assign timer_a = g_timer[0].tv;
assign timer_b = g_timer[1].tv;

////////////////////////////////////////////////////////////////////////
// machining time counter with run/clear control

// machining time and its run control
reg [31:0] mach_time_q;
reg time_run_q;
// clear is a one-shot command bit; it is never stored and reads back as zero
wire time_clear = wr_ctl && pwdata[`MSV_CTL_CLEAR_BIT];

// run bit of the time control word, read back at bit 0
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        time_run_q <= 1'b0;
    else if (wr_ctl)
        time_run_q <= pwdata[`MSV_CTL_RUN_BIT];
end

// ms count while running; clear control wins over the tick
// same tick as the timers, so both age at one rate
// wraps after about 49 days of run time; no saturation
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        mach_time_q <= 32'h00000000;
    else if (time_clear)
        mach_time_q <= 32'h00000000;
    else if (time_run_q && tick_ms)
        mach_time_q <= mach_time_q + 32'h00000001;
end

////////////////////////////////////////////////////////////////////////
// read/write variables

// auto mode edge detect
// auto_mode is taken as synchronous, so one flop is enough
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        auto_q <= 1'b0;
    else
        auto_q <= auto_mode;
end

// program end increments; the event beats a same-cycle write
// a write on the same edge as an end is lost; the machine count is the truth
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        workpiece_count <= 32'h00000000;
    else if (program_end)
        workpiece_count <= workpiece_count + 32'h00000001;
    else if (wr_count)
        workpiece_count <= pwdata;
end

// tool command loads target number, machine event over software
// number is not range checked; the turret decides what is legal
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        target_tool_number <= 32'h00000000;
    else if (tool_cmd)
        target_tool_number <= tool_cmd_number;
    else if (wr_ttool)
        target_tool_number <= pwdata;
end

// target offset held inside 0..64 on either path
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        target_tool_offset <= 32'h00000000;
    else if (tool_cmd)
        target_tool_offset <= clamp_offset(tool_cmd_offset);
    else if (wr_toff)
        target_tool_offset <= clamp_offset(pwdata);
end

// G and M keys count only in auto; outside it a press is dropped, not queued; X clears in any mode
wire press_g = auto_mode && key_g;
wire press_m = auto_mode && key_m;
wire key_clear = key_x || auto_entry;
// a written 71 or 77 is stored as written; any other value clears
wire key_code_ok = pwdata == `MSV_KEY_G || pwdata == `MSV_KEY_M;

// key capture in auto; clears; key press wins over clears
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        operator_branch_key <= 32'h00000000;
    else if (press_g)
        operator_branch_key <= `MSV_KEY_G;
    else if (press_m)
        operator_branch_key <= `MSV_KEY_M;
    else if (key_clear)
        operator_branch_key <= 32'h00000000;
    // only 71, 77 or zero held
    else if (wr_key)
        operator_branch_key <= key_code_ok ? pwdata : 32'h00000000;
end

// one-cycle strobe tells the machine a parameter changed
// registered, so the machine sees the strobe one cycle after the write edge
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        param_write <= 1'b0;
    else
        param_write <= wr_count || wr_ttool || wr_toff || wr_key || wr_ta || wr_tb;
end

////////////////////////////////////////////////////////////////////////
// read-only records

// records of machine events, never written by software
reg [31:0] speed_prog_q;
reg [31:0] cur_tool_q;
reg [31:0] cur_off_q;

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        speed_prog_q <= 32'h00000000;
    else if (speed_cmd)
        speed_prog_q <= speed_cmd_value;
end

// tool change record; number and offset move together
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        cur_tool_q <= 32'h00000000;
        cur_off_q <= 32'h00000000;
    end
    else if (tool_change_done)
    begin
        cur_tool_q <= tool_done_number;
        cur_off_q <= clamp_offset(tool_done_offset);
    end
end

// encoder held within 0..4x line count; limit is a shift
// four counts per line from quadrature; settings of 2^30 and above lose their top bits
wire [31:0] enc_limit = {encoder_line_count_setting[29:0], 2'b00};
// a count past the limit is a glitch or a stale setting; show the limit, not a wrap
wire [31:0] enc_pos = encoder_count > enc_limit ? enc_limit : encoder_count;

////////////////////////////////////////////////////////////////////////
// read mux; all words 32-bit signed, passed unchanged
// read-only words ignore writes, so a read shows what the machine holds

reg [31:0] rd_word_d;

// next read word for the offset on the bus
always @*
begin
    case (paddr)
        `MSV_OFS_WORKPIECE_COUNT: rd_word_d = workpiece_count;
        `MSV_OFS_MACHINING_TIME: rd_word_d = mach_time_q;
        `MSV_OFS_SPEED_ACTUAL: rd_word_d = spindle_rpm;
        `MSV_OFS_SPEED_PROGRAMMED: rd_word_d = speed_prog_q;
        `MSV_OFS_TARGET_TOOL_NUMBER: rd_word_d = target_tool_number;
        `MSV_OFS_TARGET_TOOL_OFFSET: rd_word_d = target_tool_offset;
        `MSV_OFS_CURRENT_TOOL_NUMBER: rd_word_d = cur_tool_q;
        `MSV_OFS_CURRENT_TOOL_OFFSET: rd_word_d = cur_off_q;
        `MSV_OFS_BRANCH_KEY: rd_word_d = operator_branch_key;
        `MSV_OFS_TIMER_A: rd_word_d = timer_a;
        `MSV_OFS_TIMER_B: rd_word_d = timer_b;
        `MSV_OFS_ENCODER_POSITION: rd_word_d = enc_pos;
        `MSV_OFS_TIME_CONTROL: rd_word_d = {31'h00000000, time_run_q};
        default: rd_word_d = 32'h00000000;
    endcase
end

// capture in the setup cycle; the word stands until the next read setup
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        prdata <= 32'h00000000;
    else if (rd_setup)
        prdata <= rd_word_d;
end

endmodule
`default_nettype wire

// File: rtl/msv_countdown.v
`timescale 1ns/1ps
`default_nettype none
`include "msv_map.vh"
module msv_countdown (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // control
    input wire tick_ms,
    input wire auto_mode,
    input wire load,
    input wire [31:0] load_value,
    // state
    output reg [31:0] value
);
// decrement in auto; load has priority over the tick
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        value <= 32'h00000000;
    else if (load)
        value <= load_value;
    else if (auto_mode && tick_ms && value != 32'h00000000)
        value <= value - 32'h00000001;
end
endmodule
`default_nettype wire

// File: rtl/msv_ms_tick.v
`timescale 1ns/1ps
`default_nettype none
`include "msv_map.vh"
module msv_ms_tick #(
    parameter [15:0] TICK_CYCLES = `MSV_TICK_CYCLES
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // one-cycle pulse every millisecond
    output reg tick_ms
);
reg [15:0] count_q;
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        count_q <= 16'h0000;
        tick_ms <= 1'b0;
    end
    else if (count_q == TICK_CYCLES - 16'h0001)
    begin
        count_q <= 16'h0000;
        tick_ms <= 1'b1;
    end
    else
    begin
        count_q <= count_q + 16'h0001;
        tick_ms <= 1'b0;
    end
end
endmodule
`default_nettype wire

// File: testbench/msv_bank_sva.sv
`timescale 1ns/1ps
`default_nettype none
module msv_bank_sva (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    // events
    input wire logic auto_mode,
    input wire logic key_g,
    input wire logic key_m,
    input wire logic key_x,
    input wire logic program_end,
    input wire logic tool_cmd,
    input wire logic [31:0] tool_cmd_number,
    // copies
    input wire logic [31:0] workpiece_count,
    input wire logic [31:0] target_tool_number,
    input wire logic [31:0] target_tool_offset,
    input wire logic [31:0] operator_branch_key,
    input wire logic param_write
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // access phase of a counter write
    wire wr_wpc = psel && penable && pwrite && paddr == 12'h000;
    ////////////////////////////////////////
    // count step
    a_wpc_step: assert property (program_end && !wr_wpc |=> workpiece_count == $past(workpiece_count) + 32'h1)
        else $error("count not stepped");
    a_wpc_write: assert property (wr_wpc && !program_end |=> workpiece_count == $past(pwdata))
        else $error("count write lost");
    a_param_pulse: assert property (wr_wpc |=> param_write)
        else $error("no parameter write");
    a_tool_load: assert property (tool_cmd |=> target_tool_number == $past(tool_cmd_number))
        else $error("tool not loaded");
    a_off_range: assert property (target_tool_offset <= 32'h40)
        else $error("offset above 64");
    a_key_g: assert property (auto_mode && $past(auto_mode) && key_g && !key_m && !key_x |=> operator_branch_key == 32'h47)
        else $error("g key not stored");
    a_key_x: assert property (key_x && !key_g && !key_m |=> operator_branch_key == 32'h0)
        else $error("x key no clear");
    a_auto_entry: assert property ($rose(auto_mode) && !key_g && !key_m |=> operator_branch_key == 32'h0)
        else $error("auto entry no clear");
    a_key_codes: assert property (operator_branch_key inside {32'h0, 32'h47, 32'h4d})
        else $error("bad branch code");
endmodule
bind msv_bank msv_bank_sva u_sva (.*);
`default_nettype wire

// File: testbench/msv_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
module msv_bank_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    wire pready;
    wire pslverr;
    wire auto;
    wire [6:0] ev;
    wire [31:0] prdata, da, db, rpm, enc, lines;
    logic [31:0] r;
    logic [31:0] t;
    logic e;
    int n_fail = 0;
    int compares = 0;
    int cyc = 0;
    msv_machine_model mdl (.pclk(pclk), .ev(ev), .da(da), .db(db), .auto(auto), .rpm(rpm), .enc(enc),
        .lines(lines));
    msv_bank uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .auto_mode(auto), .key_g(ev[0]), .key_m(ev[1]), .key_x(ev[2]), .program_end(ev[3]),
        .speed_cmd(ev[4]), .speed_cmd_value(da), .tool_cmd(ev[5]), .tool_cmd_number(da),
        .tool_cmd_offset(db), .tool_change_done(ev[6]), .tool_done_number(da), .tool_done_offset(db),
        .spindle_rpm(rpm), .encoder_count(enc), .encoder_line_count_setting(lines),
        .workpiece_count(), .target_tool_number(), .target_tool_offset(), .operator_branch_key(),
        .param_write());
    ////////////////////////////////////////
    // 40 MHz clock
    initial
    begin
        forever #12.5 pclk = ~pclk;
    end
    task complete_run;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] x);
        compares++;
        if (g !== x)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h want %h", $time, g, x);
        end
    endtask
    // one apb transfer, then an idle edge so back-to-back calls never reassign psel
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // wait for the slave; pready high or the hang guard ends a wait
        while (pready !== 1'b1)
            @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(r, x);
    endtask
    // hang guard, run needs about 40200 cycles
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            n_fail++;
            complete_run;
        end
    end
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 12; i++)
            rd(12'(i * 4), i == 2 ? 32'd1500 : i == 11 ? 32'd1000 : 32'h0);
        apb(1'b1, 12'h000, 32'hfffffff6);
        rd(12'h000, 32'hfffffff6);
        apb(1'b1, 12'h004, 32'h1234);
        rd(12'h004, 32'h0);
        rd(12'h040, 32'h0);
        chk(32'(e), 32'h1);
        mdl.pulse(3, 32'h0, 32'h0);
        rd(12'h000, 32'hfffffff7);
        mdl.pulse(4, 32'd2000, 32'h0);
        rd(12'h00c, 32'd2000);
        mdl.pulse(5, 32'd5, 32'd70);
        rd(12'h010, 32'd5);
        rd(12'h014, 32'h40);
        mdl.pulse(6, 32'd3, 32'd12);
        rd(12'h018, 32'd3);
        rd(12'h01c, 32'd12);
        apb(1'b1, 12'h010, 32'd9);
        rd(12'h010, 32'd9);
        mdl.enc <= 32'd5000;
        rd(12'h02c, 32'd4800);
        mdl.pulse(0, 32'h0, 32'h0);
        rd(12'h020, 32'h0);
        mdl.auto <= 1'b1;
        @(posedge pclk);
        mdl.pulse(0, 32'h0, 32'h0);
        rd(12'h020, 32'd71);
        apb(1'b1, 12'h020, 32'd77);
        rd(12'h020, 32'd77);
        apb(1'b1, 12'h020, 32'd5);
        rd(12'h020, 32'h0);
        mdl.pulse(1, 32'h0, 32'h0);
        rd(12'h020, 32'd77);
        mdl.pulse(2, 32'h0, 32'h0);
        rd(12'h020, 32'h0);
        mdl.pulse(1, 32'h0, 32'h0);
        mdl.auto <= 1'b0;
        @(posedge pclk);
        mdl.auto <= 1'b1;
        @(posedge pclk);
        rd(12'h020, 32'h0);
        // run the time counter, then load timers with in-range values
        apb(1'b1, 12'h030, 32'h1);
        apb(1'b1, 12'h024, 32'd5);
        apb(1'b1, 12'h028, 32'd1);
        repeat (40001) @(posedge pclk);
        apb(1'b0, 12'h024, 32'h0);
        t = r;
        chk(32'(t > 32'd2 && t < 32'd5), 32'h1);
        rd(12'h028, 32'h0);
        rd(12'h004, 32'd5 - t);
        rd(12'h030, 32'h1);
        apb(1'b1, 12'h030, 32'h2);
        rd(12'h004, 32'h0);
        rd(12'h030, 32'h0);
        complete_run;
    end
endmodule
`default_nettype wire

// File: testbench/msv_machine_model.sv
`timescale 1ns/1ps
`default_nettype none
module msv_machine_model (
    // clock
    input wire logic pclk,
    // pulses: g m x end speed tool done
    output logic [6:0] ev = 7'h0,
    // event data, scrambled when idle
    output logic [31:0] da = 32'h0,
    output logic [31:0] db = 32'h0,
    // levels
    output logic auto = 1'b0,
    output logic [31:0] rpm = 32'd1500,
    output logic [31:0] enc = 32'd1000,
    output logic [31:0] lines = 32'd1200
);
    ////////////////////////////////////////
    // one-cycle event; stale data inverted so it is never reused
    task pulse(input int i, input logic [31:0] a, input logic [31:0] b);
        ev[i] <= 1'b1;
        da <= a;
        db <= b;
        @(posedge pclk);
        ev <= 7'h0;
        da <= ~a;
        db <= ~b;
        @(posedge pclk);
    endtask
endmodule
`default_nettype wire
